// *** src/gas_out_ctrl.sv ***
// Gas reading output control: warm-up hold, fault, freeze, mapping, serial
//
// Local design decisions: the strobed register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module gas_out_ctrl #(
    parameter int SEC_TICKS = gas_out_pkg::SEC_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Calculated gas reading and its strobe
    input wire logic signed [gas_out_pkg::RW-1:0] gas_in,
    input wire logic gas_valid,
    // Self-check failures
    input wire logic mem_fail,
    input wire logic supply_fail,
    input wire logic analog_fail,
    // Transient detectors
    input wire logic amb_temp_step,
    input wire logic samp_temp_step,
    input wire logic flow_step,
    // Register port
    input wire logic [gas_out_pkg::AW-1:0] addr,
    input wire logic [gas_out_pkg::RW-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [gas_out_pkg::RW-1:0] rdata,
    // Analogue output code, serial line, interrupt
    output logic [gas_out_pkg::DW-1:0] dac_code,
    output logic txd,
    output logic irq
);
    import gas_out_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------

    // Register address hit
    function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
        hit = (a == off);
    endfunction

    // Map a reading to an output code, clamped to the converter range
    function automatic logic [11:0] map_dac(input logic signed [15:0] r,
                                            input logic [11:0] z,
                                            input logic [11:0] s,
                                            input logic fall);
        logic signed [13:0] slope;
        logic signed [29:0] prod;
        logic signed [19:0] step;
        logic signed [20:0] v;
        slope = 14'($signed({2'h0, s}) - $signed({2'h0, z}));
        prod = 30'(slope * r);
        step = 20'(prod >>> FS_SHIFT);
        // Falling output inverts the slope
        if (fall) begin
            v = 21'($signed({9'h000, z}) - step);
        end else begin
            v = 21'($signed({9'h000, z}) + step);
        end
        if (v < 21'sh000000) begin
            map_dac = DAC_OFF;
        end else if (v > 21'sh000FFF) begin
            map_dac = DAC_MAX;
        end else begin
            map_dac = v[11:0];
        end
    endfunction

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------

    logic [3:0] ctrl_ff; // Polarity, baud, scaled variant
    logic [3:0] nxt_ctrl;
    logic [11:0] start_ff; // Warm-up output level
    logic [11:0] nxt_start;
    logic [7:0] warmup_ff; // Warm-up seconds
    logic [7:0] nxt_warmup;
    logic [11:0] zero_ff; // Zero-gas output code
    logic [11:0] nxt_zero;
    logic [11:0] span_ff; // Full-scale output code
    logic [11:0] nxt_span;
    logic [3:0] status_ff; // Sticky events
    logic [3:0] nxt_status;
    logic [3:0] mask_ff; // Interrupt enables
    logic [3:0] nxt_mask;
    logic irq_ff;
    logic nxt_irq;
    logic [15:0] rdata_ff;
    logic [15:0] nxt_rdata;
    logic fault_ff; // Any self-check failing
    logic frozen_ff; // Transient in progress
    logic signed [15:0] held_ff; // Last live reading
    logic signed [15:0] nxt_held;
    logic signed [15:0] ser_ff; // Reading for serial link
    logic signed [15:0] nxt_ser;
    logic [11:0] dac_ff;
    logic [11:0] nxt_dac;
    logic [11:0] live_dac; // Mapped held reading
    logic fault_now;
    logic freeze_now;
    logic warm; // Warm-up hold active
    logic warm_done;
    logic [3:0] ev; // Event pulses
    tx_st_t st_ff;
    tx_st_t nxt_st;
    logic tx_start_ff;
    logic nxt_tx_start;
    logic [7:0] tx_byte_ff;
    logic [7:0] nxt_tx_byte;
    logic [15:0] snap_ff; // Reading being sent
    logic [15:0] nxt_snap;
    logic sent;
    logic tx_busy;
    logic [15:0] div;

    // ------------------------------------------------------------
    // Sub-blocks
    // ------------------------------------------------------------

    // Warm-up interval
    warmup_timer #(.SEC_TICKS(SEC_TICKS)) u_warm (
        .clk(clk),
        .srst(srst),
        .secs(warmup_ff),
        .warm(warm),
        .done(warm_done)
    );

    // Serial byte transmitter
    serial_tx u_tx (
        .clk(clk),
        .srst(srst),
        .div(div),
        .start(tx_start_ff),
        .data(tx_byte_ff),
        .txd(txd),
        .busy(tx_busy)
    );

    // Bit period from baud selection
    always_comb begin
        unique case (ctrl_ff[CTRL_BAUD_LSB +: 2])
            BAUD_SEL_HI: div = DIV_HI;
            BAUD_SEL_MID: div = DIV_MID;
            default: div = DIV_LO;
        endcase
    end

    // ------------------------------------------------------------
    // Register file and interrupt
    // ------------------------------------------------------------

    // Writes, write-one-to-clear status, read mux
    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_start = start_ff;
        nxt_warmup = warmup_ff;
        nxt_zero = zero_ff;
        nxt_span = span_ff;
        nxt_mask = mask_ff;
        nxt_status = status_ff;
        if (wr && hit(addr, REG_CTRL)) nxt_ctrl = wdata[3:0];
        if (wr && hit(addr, REG_START)) nxt_start = wdata[11:0];
        if (wr && hit(addr, REG_WARMUP)) nxt_warmup = wdata[7:0];
        if (wr && hit(addr, REG_ZERO)) nxt_zero = wdata[11:0];
        if (wr && hit(addr, REG_SPAN)) nxt_span = wdata[11:0];
        if (wr && hit(addr, REG_MASK)) nxt_mask = wdata[3:0];
        if (wr && hit(addr, REG_STATUS)) nxt_status = status_ff & ~wdata[3:0];
        // New events win over a clear
        nxt_status = nxt_status | ev;
        nxt_irq = |(nxt_status & nxt_mask);
        nxt_rdata = '0;
        if (rd) begin
            unique case (addr)
                REG_CTRL: nxt_rdata = {12'h000, ctrl_ff};
                REG_START: nxt_rdata = {4'h0, start_ff};
                REG_WARMUP: nxt_rdata = {8'h00, warmup_ff};
                REG_ZERO: nxt_rdata = {4'h0, zero_ff};
                REG_SPAN: nxt_rdata = {4'h0, span_ff};
                REG_STATUS: nxt_rdata = {12'h000, status_ff};
                REG_MASK: nxt_rdata = {12'h000, mask_ff};
                REG_STATE: nxt_rdata = {12'h000, tx_busy, frozen_ff, fault_ff, warm};
                REG_READING: nxt_rdata = ser_ff;
                REG_DAC: nxt_rdata = {4'h0, dac_ff};
                default: nxt_rdata = '0;
            endcase
        end
    end

    // Register file flops; start level resets to zero-gas code
    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl_ff <= CTRL_RST;
            start_ff <= START_RST;
            warmup_ff <= WARMUP_S_RST;
            zero_ff <= ZERO_RST;
            span_ff <= SPAN_RST;
            mask_ff <= MASK_RST;
            status_ff <= '0;
            irq_ff <= 1'b0;
            rdata_ff <= '0;
        end else begin
            ctrl_ff <= nxt_ctrl;
            start_ff <= nxt_start;
            warmup_ff <= nxt_warmup;
            zero_ff <= nxt_zero;
            span_ff <= nxt_span;
            mask_ff <= nxt_mask;
            status_ff <= nxt_status;
            irq_ff <= nxt_irq;
            rdata_ff <= nxt_rdata;
        end
    end

    // ------------------------------------------------------------
    // Reading path
    // ------------------------------------------------------------

    // Fault, freeze, clamp, and output selection
    always_comb begin
        fault_now = mem_fail | supply_fail | analog_fail;
        freeze_now = amb_temp_step | samp_temp_step | flow_step;
        ev = '0;
        ev[EV_FAULT] = fault_now & ~fault_ff;
        ev[EV_FREEZE] = freeze_now & ~frozen_ff;
        ev[EV_WARM] = warm_done;
        ev[EV_SENT] = sent;
        nxt_held = held_ff;
        // Freeze holds the last live value
        if (gas_valid && !frozen_ff) begin
            if (gas_in > OVER_LIMIT) begin
                nxt_held = OVER_LIMIT;
            end else if (gas_in < FAULT_READING) begin
                nxt_held = FAULT_READING;
            end else begin
                nxt_held = gas_in;
            end
        end
        live_dac = map_dac(held_ff, zero_ff, span_ff, ctrl_ff[CTRL_POL_BIT]);
        // Fault first, then warm-up hold, then live value
        if (fault_ff) begin
            nxt_ser = FAULT_READING;
            if (ctrl_ff[CTRL_SCALED_BIT]) begin
                nxt_dac = DAC_OFF;
            end else begin
                nxt_dac = map_dac(FAULT_READING, zero_ff, span_ff,
                                  ctrl_ff[CTRL_POL_BIT]);
            end
        end else if (warm) begin
            nxt_ser = '0;
            nxt_dac = start_ff;
        end else begin
            nxt_ser = held_ff;
            nxt_dac = live_dac;
        end
    end

    // Reading path flops
    always_ff @(posedge clk) begin
        if (srst) begin
            fault_ff <= 1'b0;
            frozen_ff <= 1'b0;
            held_ff <= '0;
            ser_ff <= '0;
            dac_ff <= START_RST;
        end else begin
            fault_ff <= fault_now;
            frozen_ff <= freeze_now;
            held_ff <= nxt_held;
            ser_ff <= nxt_ser;
            dac_ff <= nxt_dac;
        end
    end

    // ------------------------------------------------------------
    // Serial frame: low byte then high byte per sample taken while idle
    // ------------------------------------------------------------

    // Sequencer; a sample arriving mid-frame is skipped
    always_comb begin
        nxt_st = st_ff;
        nxt_tx_start = 1'b0;
        nxt_tx_byte = tx_byte_ff;
        nxt_snap = snap_ff;
        sent = 1'b0;
        unique case (st_ff)
            TX_IDLE: begin
                if (gas_valid) begin
                    nxt_snap = ser_ff;
                    nxt_tx_byte = ser_ff[7:0];
                    nxt_tx_start = 1'b1;
                    nxt_st = TX_LO;
                end
            end
            TX_LO: begin
                if (!tx_busy && !tx_start_ff) begin
                    nxt_tx_byte = snap_ff[15:8];
                    nxt_tx_start = 1'b1;
                    nxt_st = TX_HI;
                end
            end
            TX_HI: begin
                if (!tx_busy && !tx_start_ff) begin
                    sent = 1'b1;
                    nxt_st = TX_IDLE;
                end
            end
        endcase
    end

    // Sequencer flops
    always_ff @(posedge clk) begin
        if (srst) begin
            st_ff <= TX_IDLE;
            tx_start_ff <= 1'b0;
            tx_byte_ff <= '0;
            snap_ff <= '0;
        end else begin
            st_ff <= nxt_st;
            tx_start_ff <= nxt_tx_start;
            tx_byte_ff <= nxt_tx_byte;
            snap_ff <= nxt_snap;
        end
    end

    assign rdata = rdata_ff;
    assign dac_code = dac_ff;
    assign irq = irq_ff;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------

    sequence held_s;
        warm && !fault_ff;
    endsequence
    sequence live_s;
        !warm && !fault_ff;
    endsequence
    warm_level_a: assert property (@(posedge clk) disable iff (srst)
        held_s |=> dac_ff == $past(start_ff))
        else $error("warm-up level not driven");
    start_zero_a: assert property (@(posedge clk)
        srst |=> start_ff == ZERO_RST && dac_ff == ZERO_RST)
        else $error("start level not zero-gas");
    live_out_a: assert property (@(posedge clk) disable iff (srst)
        live_s |=> dac_ff == $past(live_dac))
        else $error("live value not driven");
    warm_ser_a: assert property (@(posedge clk) disable iff (srst)
        held_s |=> ser_ff == 16'sh0000)
        else $error("serial not zero in warm-up");
    fault_det_a: assert property (@(posedge clk) disable iff (srst)
        (mem_fail || supply_fail || analog_fail) |=> fault_ff)
        else $error("fault not raised");
    fault_ser_a: assert property (@(posedge clk) disable iff (srst)
        fault_ff |=> ser_ff == FAULT_READING)
        else $error("serial not minus full scale");
    fault_zero_v_a: assert property (@(posedge clk) disable iff (srst)
        fault_ff && ctrl_ff[CTRL_SCALED_BIT] |=> dac_ff == DAC_OFF)
        else $error("scaled fault not 0 V");
    freeze_hold_a: assert property (@(posedge clk) disable iff (srst)
        frozen_ff |=> held_ff == $past(held_ff))
        else $error("frozen reading moved");
    clamp_top_a: assert property (@(posedge clk) disable iff (srst)
        held_ff <= OVER_LIMIT)
        else $error("reading above limit");
    fall_dir_a: assert property (@(posedge clk) disable iff (srst)
        live_s and (ctrl_ff[CTRL_POL_BIT] && held_ff > 16'sh0000 && span_ff > zero_ff)
        |=> dac_ff <= $past(zero_ff))
        else $error("falling output rose");
    baud_a: assert property (@(posedge clk) disable iff (srst)
        ctrl_ff[2:1] == BAUD_SEL_HI |-> div == DIV_HI)
        else $error("default baud wrong");
endmodule
`default_nettype wire

// *** src/gas_out_pkg.sv ***
// Constants, register map and types for the gas reading output control
// ----------------------------------------------------------------------
// Overview of operation
// - Output held at start-up level from power-on.
// - Start-up level defaults to the zero-gas value.
// - Hold lasts 15 s, then calculated value.
// - Serial reading is zero throughout a fault-free warm-up.
// - Start level and warm-up time are presettable.
// - Memory, supply, signal checks raise a fault.
// - Fault forces reading to minus full scale.
// - Scaled voltage variant drives 0 V on fault.
// - Serial reading is minus full scale on fault.
// - Serial framing is 8 data, 1 stop, no parity.
// - Transients freeze output until they settle.
// - Setting selects rising or falling output.
// - 38400, 19200, 9600 baud; 38400 default.
// - Reading saturates at twice full scale.
// ----------------------------------------------------------------------
package gas_out_pkg;
    // Clock and timing
    localparam int CLK_HZ = 10_000_000;
    localparam int SEC_S = 1;
    localparam int SEC_CYCLES = CLK_HZ * SEC_S;
    localparam logic [7:0] WARMUP_S_RST = 8'h0F;
    localparam int BAUD_HI = 38400;
    localparam int BAUD_MID = 19200;
    localparam int BAUD_LO = 9600;
    localparam logic [15:0] DIV_HI = 16'(CLK_HZ / BAUD_HI);
    localparam logic [15:0] DIV_MID = 16'(CLK_HZ / BAUD_MID);
    localparam logic [15:0] DIV_LO = 16'(CLK_HZ / BAUD_LO);
    localparam logic [1:0] BAUD_SEL_HI = 2'h0;
    localparam logic [1:0] BAUD_SEL_MID = 2'h1;
    // Widths
    localparam int RW = 16;
    localparam int DW = 12;
    localparam int AW = 4;
    localparam int EVW = 4;
    // Reading scale: full scale is 2^FS_SHIFT counts
    localparam int FS_SHIFT = 10;
    localparam logic signed [15:0] FULL_SCALE_VALUE = 16'sh0400;
    localparam logic signed [15:0] OVER_LIMIT = 16'sh0800;
    localparam logic signed [15:0] FAULT_READING = 16'shFC00;
    localparam logic [11:0] DAC_OFF = 12'h000;
    localparam logic [11:0] DAC_MAX = 12'hFFF;
    // Register offsets
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_START = 4'h1;
    localparam logic [3:0] REG_WARMUP = 4'h2;
    localparam logic [3:0] REG_ZERO = 4'h3;
    localparam logic [3:0] REG_SPAN = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h5;
    localparam logic [3:0] REG_MASK = 4'h6;
    localparam logic [3:0] REG_STATE = 4'h7;
    localparam logic [3:0] REG_READING = 4'h8;
    localparam logic [3:0] REG_DAC = 4'h9;
    // Control fields
    localparam int CTRL_POL_BIT = 0;
    localparam int CTRL_BAUD_LSB = 1;
    localparam int CTRL_SCALED_BIT = 3;
    localparam logic [3:0] CTRL_RST = 4'h0;
    // Status / mask event bits
    localparam int EV_FAULT = 0;
    localparam int EV_FREEZE = 1;
    localparam int EV_WARM = 2;
    localparam int EV_SENT = 3;
    // Reset values
    localparam logic [11:0] ZERO_RST = 12'h200;
    localparam logic [11:0] SPAN_RST = 12'hC00;
    localparam logic [11:0] START_RST = ZERO_RST;
    localparam logic [3:0] MASK_RST = 4'h0;
    // Serial frame sequencer states
    typedef enum logic [1:0] {TX_IDLE, TX_LO, TX_HI} tx_st_t;
endpackage

// *** src/warmup_timer.sv ***
// Warm-up interval timer counting whole seconds from reset
`timescale 1ns/100ps
`default_nettype none
module warmup_timer #(
    parameter int SEC_TICKS = gas_out_pkg::SEC_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Interval length in seconds
    input wire logic [7:0] secs,
    // Hold state and end pulse
    output logic warm,
    output logic done
);
    import gas_out_pkg::*;

    logic [31:0] tick_ff; // Cycles within the current second
    logic [31:0] nxt_tick;
    logic [7:0] sec_ff; // Whole seconds elapsed
    logic [7:0] nxt_sec;
    logic warm_ff; // High while holding
    logic nxt_warm;
    logic done_ff; // One-cycle end pulse
    logic nxt_done;

    // Next-state: count seconds until interval reached
    always_comb begin
        nxt_tick = tick_ff;
        nxt_sec = sec_ff;
        nxt_warm = warm_ff;
        nxt_done = 1'b0;
        if (warm_ff) begin
            if (sec_ff >= secs) begin
                // Interval over
                nxt_warm = 1'b0;
                nxt_done = 1'b1;
            end else if (tick_ff == 32'(SEC_TICKS - 1)) begin
                nxt_tick = '0;
                nxt_sec = sec_ff + 8'h01;
            end else begin
                nxt_tick = tick_ff + 32'h0000_0001;
            end
        end
    end

    // State registers; hold starts at reset
    always_ff @(posedge clk) begin
        if (srst) begin
            tick_ff <= '0;
            sec_ff <= '0;
            warm_ff <= 1'b1;
            done_ff <= 1'b0;
        end else begin
            tick_ff <= nxt_tick;
            sec_ff <= nxt_sec;
            warm_ff <= nxt_warm;
            done_ff <= nxt_done;
        end
    end

    assign warm = warm_ff;
    assign done = done_ff;

    // Hold never ends before the programmed seconds pass
    early_end_a: assert property (@(posedge clk) disable iff (srst)
        $fell(warm_ff) |-> $past(sec_ff) >= $past(secs))
        else $error("warm-up ended early");
endmodule
`default_nettype wire

// *** src/serial_tx.sv ***
// Asynchronous serial transmitter, 8 data bits, 1 stop bit, no parity
`timescale 1ns/100ps
`default_nettype none
module serial_tx (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Bit period in clock cycles
    input wire logic [15:0] div,
    // Byte request
    input wire logic start,
    input wire logic [7:0] data,
    // Line and busy flag
    output logic txd,
    output logic busy
);
    import gas_out_pkg::*;

    logic [9:0] shift_ff; // Stop, data, start
    logic [9:0] nxt_shift;
    logic [3:0] bits_ff; // Bit index within frame
    logic [3:0] nxt_bits;
    logic [15:0] cnt_ff; // Cycles within bit
    logic [15:0] nxt_cnt;
    logic busy_ff;
    logic nxt_busy;
    logic txd_ff;
    logic nxt_txd;

    // Next-state: load frame, then shift one bit per period
    always_comb begin
        nxt_shift = shift_ff;
        nxt_bits = bits_ff;
        nxt_cnt = cnt_ff;
        nxt_busy = busy_ff;
        if (!busy_ff) begin
            if (start) begin
                // Start low, 8 data LSB first, one stop high
                nxt_shift = {1'b1, data, 1'b0};
                nxt_bits = '0;
                nxt_cnt = '0;
                nxt_busy = 1'b1;
            end
        end else if (cnt_ff == div - 16'h0001) begin
            nxt_cnt = '0;
            if (bits_ff == 4'h9) begin
                nxt_busy = 1'b0;
            end else begin
                nxt_shift = {1'b1, shift_ff[9:1]};
                nxt_bits = bits_ff + 4'h1;
            end
        end else begin
            nxt_cnt = cnt_ff + 16'h0001;
        end
        nxt_txd = nxt_busy ? nxt_shift[0] : 1'b1;
    end

    // Registers; line idles high
    always_ff @(posedge clk) begin
        if (srst) begin
            shift_ff <= '1;
            bits_ff <= '0;
            cnt_ff <= '0;
            busy_ff <= 1'b0;
            txd_ff <= 1'b1;
        end else begin
            shift_ff <= nxt_shift;
            bits_ff <= nxt_bits;
            cnt_ff <= nxt_cnt;
            busy_ff <= nxt_busy;
            txd_ff <= nxt_txd;
        end
    end

    assign txd = txd_ff;
    assign busy = busy_ff;

    // Accepted byte starts with a low start bit
    sequence take_s;
        start && !busy_ff;
    endsequence
    start_bit_a: assert property (@(posedge clk) disable iff (srst)
        take_s |=> !txd_ff && busy_ff)
        else $error("start bit missing");
    // Stop bit is high when the frame ends
    stop_bit_a: assert property (@(posedge clk) disable iff (srst)
        $fell(busy_ff) |-> $past(txd_ff) && $past(bits_ff) == 4'h9)
        else $error("stop bit wrong");
endmodule
`default_nettype wire

// *** src/placeholder_none.sv ***
// Intentionally empty compile unit
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// *** verif/host_rx_model.sv ***
// Host-side serial receiver model, 8 data bits, 1 stop bit
`timescale 1ns/100ps
`default_nettype none
module host_rx_model (
    // Clock, line, bit period
    input wire logic clk,
    input wire logic txd,
    input wire logic [15:0] div,
    // Byte, strobe, framing flag
    output logic [7:0] rx_byte,
    output logic rx_stb,
    output logic frame_err
);
    // Mid-bit sampling, LSB first, stop bit checked
    initial begin
        rx_byte = 8'h00;
        rx_stb = 1'b0;
        frame_err = 1'b0;
        forever begin
            @(negedge txd);
            repeat (div / 2) @(posedge clk);
            for (int i = 0; i < 8; i++) begin
                repeat (div) @(posedge clk);
                rx_byte[i] = txd;
            end
            repeat (div) @(posedge clk);
            frame_err = frame_err | ~txd;
            rx_stb <= 1'b1;
            @(posedge clk);
            rx_stb <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// *** verif/gas_reading_output_control_test.sv ***
// Self-checking bench for the gas reading output control
`timescale 1ns/100ps
`default_nettype none
module gas_reading_output_control_test;
    import gas_out_pkg::*;
    logic clk, srst, gas_valid, wr, rd, txd, irq, rx_stb, frame_err;
    logic signed [RW-1:0] gas_in;
    logic [2:0] fail_v, step_v;
    logic [AW-1:0] addr;
    logic [RW-1:0] wdata, rdata, got;
    logic [DW-1:0] dac_code;
    logic [7:0] rx_byte;
    logic [15:0] div;
    logic [31:0] seed = 32'h2726;
    logic [7:0] rxq[$];
    int fail_count = 0, checked = 0, cycles = 0;
    gas_out_ctrl #(.SEC_TICKS(20)) i_dut (.clk(clk), .srst(srst), .gas_in(gas_in),
        .gas_valid(gas_valid), .mem_fail(fail_v[0]), .supply_fail(fail_v[1]),
        .analog_fail(fail_v[2]), .amb_temp_step(step_v[0]), .samp_temp_step(step_v[1]),
        .flow_step(step_v[2]), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .dac_code(dac_code), .txd(txd), .irq(irq));
    host_rx_model i_host (.clk(clk), .txd(txd), .div(div), .rx_byte(rx_byte),
        .rx_stb(rx_stb), .frame_err(frame_err));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Collect bytes; cut a hang short
    always @(posedge clk) begin
        if (rx_stb) rxq.push_back(rx_byte);
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            fail_count++;
            end_of_test();
        end
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [15:0] exp_rd(input int g);
        return (g > 2048) ? 16'h0800 : (g < -1024) ? 16'hFC00 : 16'(g);
    endfunction
    function automatic logic [11:0] exp_dac(input logic [15:0] r, input bit fall);
        int d;
        d = ((int'(SPAN_RST) - int'(ZERO_RST)) * int'(signed'(r))) >>> FS_SHIFT;
        d = fall ? int'(ZERO_RST) - d : int'(ZERO_RST) + d;
        return (d < 0) ? 12'h000 : (d > 4095) ? 12'hFFF : 12'(d);
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        tick(1);
        wr <= 1'b0;
        tick(1);
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
        addr <= a;
        rd <= 1'b1;
        tick(1);
        rd <= 1'b0;
        tick(1);
        check(rdata, e);
    endtask
    task automatic sample(input logic [15:0] g);
        gas_in <= g;
        gas_valid <= 1'b1;
        tick(1);
        gas_valid <= 1'b0;
        tick(4);
    endtask
    task automatic end_of_test;
        $display("checked=%0d fail_count=%0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        {srst, gas_valid, wr, rd, gas_in, fail_v, step_v, addr, wdata} = '0;
        srst = 1'b1;
        div = DIV_HI;
        tick(16);
        srst <= 1'b0;
        tick(1);
        check(dac_code, START_RST);
        wr_reg(REG_MASK, 16'h0004);
        sample(16'h0300);
        rd_chk(REG_READING, 16'h0000);
        wr_reg(REG_START, 16'h0123);
        tick(2);
        check(dac_code, 12'h123);
        tick(255);
        check({irq, dac_code}, 13'h0123);
        tick(35);
        check(irq, 1'b1);
        check(dac_code, exp_dac(16'h0300, 1'b0));
        rd_chk(REG_STATUS, 16'h0004);
        wr_reg(REG_STATUS, 16'h0004);
        rd_chk(4'hF, 16'h0000);
        check(irq, 1'b0);
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            got = exp_rd((i == 7) ? 32'h7000 : int'(seed[6:0]));
            wr_reg(REG_CTRL, {15'h0, seed[8]});
            sample((i == 7) ? 16'h7000 : {9'h0, seed[6:0]});
            check(dac_code, exp_dac(got, seed[8]));
            rd_chk(REG_READING, got);
        end
        step_v <= 3'b001 << (seed[9:8] % 3);
        tick(2);
        sample(16'h0055);
        rd_chk(REG_READING, got);
        step_v <= 3'b000;
        tick(2);
        sample(16'h0055);
        rd_chk(REG_READING, 16'h0055);
        wr_reg(REG_CTRL, 16'h0001);
        for (int k = 0; k < 3; k++) begin
            fail_v <= 3'b001 << k;
            tick(3);
            check(dac_code, exp_dac(16'hFC00, 1'b1));
            rd_chk(REG_READING, 16'hFC00);
        end
        wr_reg(REG_CTRL, 16'h0009);
        tick(3);
        check(dac_code, 12'h000);
        fail_v <= 3'b000;
        sample(16'h01A5);
        tick(6000);
        for (int b = 0; b < 3; b++) begin
            wr_reg(REG_CTRL, 16'(b << 1));
            div = (b == 0) ? DIV_HI : (b == 1) ? DIV_MID : DIV_LO;
            rxq.delete();
            sample(16'h01A5);
            for (int w = 0; w < 30000 && rxq.size() < 2; w++) tick(1);
            check({16'(rxq.size()), rxq[0], rxq[1]}, {16'h0002, 16'hA501});
            tick(1100);
        end
        check(frame_err, 1'b0);
        rd_chk(REG_STATUS, 16'h000B);
        srst <= 1'b1;
        tick(2);
        fail_v <= 3'b010;
        srst <= 1'b0;
        tick(4);
        rd_chk(REG_READING, 16'hFC00);
        rd_chk(REG_STATE, 16'h0003);
        check(dac_code, exp_dac(16'hFC00, 1'b0));
        end_of_test();
    end
endmodule
`default_nettype wire
